/* File: sor_bank.sv */
// sync word select, sync request filter and over-range configuration bank
`timescale 1ns/100ps
`default_nettype none
`include "sor_cfg.svh"

module sor_bank
(
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire sor_pkg::sor_req_t req,
   output logic [7:0] rdata,
   output logic rvalid,
   input wire logic link_enable,
   input wire logic link_mode_64b66b,
   input wire logic sync_b,
   output logic sync_request,
   output sor_pkg::sor_hdr_t hdr,
   input wire sor_pkg::sor_samples_t samples,
   output logic overrange_out_a,
   output logic overrange_out_b,
   output logic overrange_out_c,
   output logic overrange_out_d
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed
   {
      sor_pkg::sor_regs_t regs;
      sor_pkg::sor_link_state_t lstate;
      logic [5:0] low_cnt;
      logic sync_request;
      logic [7:0] rdata;
      logic rvalid;
      sor_pkg::sor_hdr_t hdr;
   } sor_st_t;

   sor_st_t st;
   sor_st_t next_st;

   logic [4:0] limit;
   assign limit = st.regs.sync_request_filter[`SOR_LIMIT_MSB:`SOR_LIMIT_LSB];

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   // one-hot register select for an address; zero when unmapped
   function automatic logic [3:0] sor_reg_sel(input logic [11:0] a);
      logic [3:0] s;
      case (a)
         `SOR_ADDR_SYNC_WORD_MODE_SELECT: s = 4'h1;
         `SOR_ADDR_SYNC_REQUEST_FILTER: s = 4'h2;
         `SOR_ADDR_OVERRANGE_LEVEL: s = 4'h4;
         `SOR_ADDR_OVERRANGE_CONFIG: s = 4'h8;
         default: s = 4'h0;
      endcase
      return s;
   endfunction

   // ----------------------------------------------------------------
   // sync sampling
   // ----------------------------------------------------------------
   // one qualified low sample of the active-low sync input
   function automatic logic sor_low_seen(input logic en, input logic s_b);
      return en && !s_b;
   endfunction

   // ----------------------------------------------------------------
   // header content
   // ----------------------------------------------------------------
   // flag for one sync word content, only in 64b/66b link modes
   function automatic logic sor_sh_pick
   (
      input logic mode,
      input logic [1:0] sel,
      input logic [1:0] code
   );
      return mode && (sel == code);
   endfunction

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      next_st = st;
      next_st.rvalid = 1'b0;
      // register port
      if (req.wr)
      begin
         case (sor_reg_sel(req.addr))
            4'h1: next_st.regs.sync_word_mode_select = req.wdata;
            4'h2: next_st.regs.sync_request_filter = req.wdata;
            4'h4: next_st.regs.overrange_level = req.wdata;
            4'h8: next_st.regs.overrange_config = req.wdata;
            default: next_st.regs = st.regs;
         endcase
      end
      if (req.rd)
      begin
         next_st.rvalid = 1'b1;
         case (sor_reg_sel(req.addr))
            4'h1: next_st.rdata = st.regs.sync_word_mode_select;
            4'h2: next_st.rdata = st.regs.sync_request_filter;
            4'h4: next_st.rdata = st.regs.overrange_level;
            4'h8: next_st.rdata = st.regs.overrange_config;
            default: next_st.rdata = 8'h00;
         endcase
      end

      // sync header content
      next_st.hdr.sync_header_select =
         st.regs.sync_word_mode_select[`SOR_SHSEL_MSB:`SOR_SHSEL_LSB];
      next_st.hdr.use_crc12 = sor_sh_pick(link_mode_64b66b, next_st.hdr.sync_header_select,
         `SOR_SH_CRC12);
      next_st.hdr.use_fec = sor_sh_pick(link_mode_64b66b, next_st.hdr.sync_header_select,
         `SOR_SH_FEC);
      next_st.hdr.cmd_field = 4'h0;

      // sync request filter, one sample per ref_clk cycle
      next_st.sync_request = 1'b0;
      case (st.lstate)
         sor_pkg::SOR_LINK_IDLE:
         begin
            next_st.low_cnt = 6'h00;
            if (sor_low_seen(link_enable, sync_b))
            begin
               next_st.low_cnt = 6'h01;
               next_st.lstate = sor_pkg::SOR_LINK_COUNT;
               if (limit == 5'h00)
               begin
                  next_st.sync_request = 1'b1;
                  next_st.lstate = sor_pkg::SOR_LINK_REQ;
               end
            end
         end
         sor_pkg::SOR_LINK_COUNT:
         begin
            if (!sor_low_seen(link_enable, sync_b))
            begin
               next_st.low_cnt = 6'h00;
               next_st.lstate = sor_pkg::SOR_LINK_IDLE;
            end
            else
            begin
               next_st.low_cnt = st.low_cnt + 6'h01;
               if (st.low_cnt >= {1'b0, limit})
               begin
                  next_st.sync_request = 1'b1;
                  next_st.lstate = sor_pkg::SOR_LINK_REQ;
               end
            end
         end
         sor_pkg::SOR_LINK_REQ:
         begin
            next_st.sync_request = sor_low_seen(link_enable, sync_b);
            if (!sor_low_seen(link_enable, sync_b))
            begin
               next_st.low_cnt = 6'h00;
               next_st.lstate = sor_pkg::SOR_LINK_IDLE;
            end
         end
         default:
         begin
            next_st.low_cnt = 6'h00;
            next_st.lstate = sor_pkg::SOR_LINK_IDLE;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
      begin
         st <= '0;
         st.regs.sync_word_mode_select <= `SOR_RST_SYNC_WORD_MODE_SELECT;
         st.regs.sync_request_filter <= `SOR_RST_SYNC_REQUEST_FILTER;
         st.regs.overrange_level <= `SOR_RST_OVERRANGE_LEVEL;
         st.regs.overrange_config <= `SOR_RST_OVERRANGE_CONFIG;
         st.lstate <= sor_pkg::SOR_LINK_IDLE;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign rdata = st.rdata;
   assign rvalid = st.rvalid;
   assign sync_request = st.sync_request;
   assign hdr = st.hdr;

   // ----------------------------------------------------------------
   // over-range channels
   // ----------------------------------------------------------------
   logic pin_en;
   logic [2:0] hold_exp;
   assign pin_en = st.regs.overrange_config[`SOR_OVERRANGE_PIN_ENABLE_BIT];
   assign hold_exp = st.regs.overrange_config[`SOR_OVERRANGE_HOLD_EXPONENT_MSB:`SOR_OVERRANGE_HOLD_EXPONENT_LSB];

   sor_ovr_chan u_ch_a
   (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .sample(samples.a),
      .level(st.regs.overrange_level),
      .pin_enable(pin_en),
      .hold_exp(hold_exp),
      .ovr_out(overrange_out_a)
   );

   sor_ovr_chan u_ch_b
   (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .sample(samples.b),
      .level(st.regs.overrange_level),
      .pin_enable(pin_en),
      .hold_exp(hold_exp),
      .ovr_out(overrange_out_b)
   );

   sor_ovr_chan u_ch_c
   (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .sample(samples.c),
      .level(st.regs.overrange_level),
      .pin_enable(pin_en),
      .hold_exp(hold_exp),
      .ovr_out(overrange_out_c)
   );

   sor_ovr_chan u_ch_d
   (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .sample(samples.d),
      .level(st.regs.overrange_level),
      .pin_enable(pin_en),
      .hold_exp(hold_exp),
      .ovr_out(overrange_out_d)
   );

endmodule
`default_nettype wire

/* File: sor_cfg.svh */
// register offsets, field positions, reset values and counts for the sync/over-range bank
`ifndef SOR_CFG_SVH
`define SOR_CFG_SVH

`define SOR_ADDR_SYNC_WORD_MODE_SELECT 12'h20F
`define SOR_ADDR_SYNC_REQUEST_FILTER 12'h210
`define SOR_ADDR_OVERRANGE_LEVEL 12'h211
`define SOR_ADDR_OVERRANGE_CONFIG 12'h213

`define SOR_RST_SYNC_WORD_MODE_SELECT 8'h00
`define SOR_RST_SYNC_REQUEST_FILTER 8'h03
`define SOR_RST_OVERRANGE_LEVEL 8'hF2
`define SOR_RST_OVERRANGE_CONFIG 8'h07

`define SOR_SHSEL_MSB 1
`define SOR_SHSEL_LSB 0
`define SOR_LIMIT_MSB 4
`define SOR_LIMIT_LSB 0
`define SOR_OVERRANGE_PIN_ENABLE_BIT 3
`define SOR_OVERRANGE_HOLD_EXPONENT_MSB 2
`define SOR_OVERRANGE_HOLD_EXPONENT_LSB 0

`define SOR_SH_CRC12 2'h0
`define SOR_SH_FEC 2'h2

`define SOR_HOLD_BASE 20'h00004
`define SOR_HOLD_W 20

`endif

/* File: sor_pkg.sv */
// types shared by the sync/over-range bank
package sor_pkg;

   typedef enum logic [2:0]
   {
      SOR_LINK_IDLE = 3'h1,
      SOR_LINK_COUNT = 3'h2,
      SOR_LINK_REQ = 3'h4
   } sor_link_state_t;

   typedef struct packed
   {
      logic [7:0] sync_word_mode_select;
      logic [7:0] sync_request_filter;
      logic [7:0] overrange_level;
      logic [7:0] overrange_config;
   } sor_regs_t;

   typedef struct packed
   {
      logic [11:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } sor_req_t;

   typedef struct packed
   {
      logic [1:0] sync_header_select;
      logic use_crc12;
      logic use_fec;
      logic [3:0] cmd_field;
   } sor_hdr_t;

   typedef struct packed
   {
      logic [11:0] a;
      logic [11:0] b;
      logic [11:0] c;
      logic [11:0] d;
   } sor_samples_t;

endpackage

/* File: sor_ovr_chan.sv */
// one channel of over-range detection with pulse extension
`timescale 1ns/100ps
`default_nettype none
`include "sor_cfg.svh"

module sor_ovr_chan
(
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic [11:0] sample,
   input wire logic [7:0] level,
   input wire logic pin_enable,
   input wire logic [2:0] hold_exp,
   output logic ovr_out
);

   typedef struct packed
   {
      logic [`SOR_HOLD_W-1:0] cnt;
      logic out;
   } sor_chan_st_t;

   sor_chan_st_t st;
   sor_chan_st_t next_st;

   // magnitude of a two's complement sample, scaled to eight bits
   function automatic logic [7:0] sor_mag8(input logic [11:0] s);
      logic [11:0] m;
      m = s[11] ? 12'(~s + 12'h001) : s;
      if (m[11])
         sor_mag8 = 8'hFF;
      else
         sor_mag8 = m[10:3];
   endfunction

   logic hit;
   assign hit = (sor_mag8(sample) >= level);

   always_comb
   begin
      next_st = st;
      if (hit)
      begin
         next_st.cnt = `SOR_HOLD_W'(`SOR_HOLD_BASE << hold_exp);
         next_st.out = 1'b1;
      end
      else if (st.cnt > `SOR_HOLD_W'h1)
      begin
         next_st.cnt = st.cnt - `SOR_HOLD_W'h1;
      end
      else
      begin
         next_st.cnt = '0;
         next_st.out = 1'b0;
      end
      if (!pin_enable)
      begin
         next_st.cnt = '0;
         next_st.out = 1'b0;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         st <= '0;
      else
         st <= next_st;
   end

   assign ovr_out = st.out;

endmodule
`default_nettype wire

/* File: sor_bank_monitor.sv */
// assertions for the sync/over-range bank
`timescale 1ns/100ps
`default_nettype none
module sor_bank_monitor
(
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire sor_pkg::sor_req_t req,
   input wire logic rvalid,
   input wire logic link_enable,
   input wire logic link_mode_64b66b,
   input wire logic sync_b,
   input wire logic sync_request,
   input wire sor_pkg::sor_hdr_t hdr,
   input wire sor_pkg::sor_samples_t samples,
   input wire logic overrange_out_a,
   input wire logic overrange_out_b,
   input wire logic overrange_out_c,
   input wire logic overrange_out_d
);
// ----
// register shadows and low-run counter
// ----
logic [4:0] lim;
logic [7:0] lvl;
logic [3:0] cfg;
logic [5:0] run;
logic [11:0] mag;
logic [7:0] m8;
always_comb
begin
   mag = samples.a[11] ? 12'h000 - samples.a : samples.a;
   m8 = mag[11] ? 8'hFF : mag[10:3];
end
always_ff @(posedge ref_clk)
begin
   if (!rst_b)
   begin
      lim <= 5'h03;
      lvl <= 8'hF2;
      cfg <= 4'h7;
      run <= 6'h00;
   end
   else
   begin
      if (req.wr && req.addr == 12'h210)
         lim <= req.wdata[4:0];
      if (req.wr && req.addr == 12'h211)
         lvl <= req.wdata;
      if (req.wr && req.addr == 12'h213)
         cfg <= req.wdata[3:0];
      run <= (link_enable && !sync_b) ? run + {5'h00, run != 6'h3F} : 6'h00;
   end
end
// ----
// properties
// ----
default clocking @(posedge ref_clk); endclocking
default disable iff (!rst_b);
sequence s_rise_en;
   $rose(overrange_out_a) && cfg[3] ##1 cfg[3] [*2];
endsequence
sequence s_hold;
   overrange_out_a && $past(overrange_out_a) ##1 overrange_out_a;
endsequence
AST_RVALID: assert property (req.rd |=> rvalid)
   else $error("read not answered");
AST_CMD_IDLE: assert property (hdr.cmd_field == 4'h0)
   else $error("command field not zero");
AST_HDR_CRC: assert property ($past(rst_b) |-> hdr.use_crc12 ==
   ($past(link_mode_64b66b) && hdr.sync_header_select == 2'h0)) else $error("crc select wrong");
AST_HDR_FEC: assert property ($past(rst_b) |-> hdr.use_fec ==
   ($past(link_mode_64b66b) && hdr.sync_header_select == 2'h2)) else $error("fec select wrong");
AST_SYNC_FILTER: assert property (sync_request == (run > {1'b0, lim}))
   else $error("sync request filter wrong");
AST_SYNC_HIGH: assert property (sync_b |=> !sync_request)
   else $error("request while sync high");
AST_OVR_OFF: assert property (!$past(cfg[3]) |->
   !(overrange_out_a | overrange_out_b | overrange_out_c | overrange_out_d))
   else $error("over-range out while disabled");
AST_OVR_HIT: assert property (cfg[3] && m8 >= lvl |=> overrange_out_a)
   else $error("over-range missed");
AST_OVR_HOLD: assert property (s_rise_en |-> s_hold)
   else $error("over-range pulse short");
endmodule
bind sor_bank sor_bank_monitor mon_u (.ref_clk(ref_clk), .rst_b(rst_b), .req(req),
   .rvalid(rvalid), .link_enable(link_enable), .link_mode_64b66b(link_mode_64b66b),
   .sync_b(sync_b), .sync_request(sync_request), .hdr(hdr), .samples(samples),
   .overrange_out_a(overrange_out_a), .overrange_out_b(overrange_out_b),
   .overrange_out_c(overrange_out_c), .overrange_out_d(overrange_out_d));
`default_nettype wire

/* File: sor_rx_model.sv */
// receiver model driving the active-low sync line
`timescale 1ns/100ps
`default_nettype none
module sor_rx_model
(
   input wire logic ref_clk,
   input wire logic go,
   input wire logic [5:0] low_len,
   output logic sync_b
);
// ----
// low run generator
// ----
logic [5:0] left = 6'h00;
initial sync_b = 1'b1;
always @(posedge ref_clk)
begin
   if (go)
      left <= low_len;
   else if (left != 6'h00)
      left <= left - 6'h01;
end
always @(negedge ref_clk)
   sync_b <= (left == 6'h00);
endmodule
`default_nettype wire

/* File: sor_bank_tb.sv */
// testbench for the sync/over-range bank
`timescale 1ns/100ps
`default_nettype none
module sor_bank_tb;
logic ref_clk = 1'b0;
logic rst_b = 1'b0;
sor_pkg::sor_req_t req = '0;
logic link_enable = 1'b0;
logic link_mode_64b66b = 1'b1;
sor_pkg::sor_samples_t samples = '0;
logic go = 1'b0;
logic [5:0] low_len = 6'h00;
logic sync_b;
logic sync_request;
logic rvalid;
logic [7:0] rdata;
sor_pkg::sor_hdr_t hdr;
logic [3:0] ovr;
logic [15:0] w;
logic seen;
int fails = 0;
int checks = 0;
always #12.5 ref_clk = ~ref_clk;
sor_bank dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .req(req), .rdata(rdata), .rvalid(rvalid),
   .link_enable(link_enable), .link_mode_64b66b(link_mode_64b66b), .sync_b(sync_b),
   .sync_request(sync_request), .hdr(hdr), .samples(samples), .overrange_out_a(ovr[0]),
   .overrange_out_b(ovr[1]), .overrange_out_c(ovr[2]), .overrange_out_d(ovr[3]));
sor_rx_model rx_u (.ref_clk(ref_clk), .go(go), .low_len(low_len), .sync_b(sync_b));
// ----
// tasks
// ----
task chk(input logic [15:0] s, input logic [15:0] e);
   checks++;
   if (s !== e)
   begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
   end
endtask
task wr(input logic [11:0] a, input logic [7:0] d);
   @(negedge ref_clk);
   req.addr = a;
   req.wdata = d;
   req.wr = 1'b1;
   @(negedge ref_clk);
   req.wr = 1'b0;
endtask
task rd(input logic [11:0] a, input logic [7:0] e);
   @(negedge ref_clk);
   req.addr = a;
   req.rd = 1'b1;
   @(negedge ref_clk);
   req.rd = 1'b0;
   chk({8'h00, rdata}, {8'h00, e});
   chk({15'h0000, rvalid}, 16'h0001);
endtask
task sync_try(input logic [5:0] n, input logic e);
   seen = 1'b0;
   low_len = n;
   go = 1'b1;
   @(negedge ref_clk);
   go = 1'b0;
   repeat (40)
   begin
      @(negedge ref_clk);
      seen = seen | sync_request;
   end
   chk({15'h0000, seen}, {15'h0000, e});
   chk({15'h0000, sync_request}, 16'h0000);
endtask
task filt(input logic [5:0] l);
   link_enable = 1'b0;
   wr(12'h210, {2'h0, l});
   link_enable = 1'b1;
   sync_try(l, 1'b0);
   sync_try(l + 6'h01, 1'b1);
endtask
task ovr_try(input logic [7:0] c, input logic [3:0] e, input logic [15:0] n);
   wr(12'h213, c);
   samples = {12'h100, 12'hF00, 12'h080, 12'h07F};
   @(negedge ref_clk);
   samples = '0;
   chk({12'h000, ovr}, {12'h000, e});
   w = 16'h0000;
   repeat (600)
   begin
      w = w + {15'h0000, ovr[0]};
      @(negedge ref_clk);
   end
   chk(w, n);
endtask
task results();
   $display("checks=%0d fails=%0d", checks, fails);
   if (fails == 0 && checks > 0)
      $display("Run complete: PASS");
   else
      $display("Run complete: FAIL");
   $finish;
endtask
// ----
// sequence
// ----
initial
begin
   repeat (2) @(negedge ref_clk);
   rst_b = 1'b1;
   rd(12'h20F, 8'h00);
   rd(12'h210, 8'h03);
   rd(12'h211, 8'hF2);
   rd(12'h213, 8'h07);
   wr(12'h212, 8'h5A);
   rd(12'h212, 8'h00);
   wr(12'h211, 8'hA5);
   rd(12'h211, 8'hA5);
   $display("test registers done");
   for (int i = 0; i < 8; i++)
   begin
      link_mode_64b66b = i[2];
      wr(12'h20F, {6'h00, i[1:0]});
      @(negedge ref_clk);
      chk({8'h00, hdr}, {8'h00, i[1:0], i[2] && i[1:0] == 2'h0,
         i[2] && i[1:0] == 2'h2, 4'h0});
   end
   $display("test header done");
   filt(6'h00);
   filt(6'h03);
   filt(6'h1F);
   link_enable = 1'b0;
   sync_try(6'h08, 1'b0);
   $display("test sync done");
   wr(12'h211, 8'h10);
   ovr_try(8'h08, 4'h7, 16'h0004);
   ovr_try(8'h0A, 4'h7, 16'h0010);
   ovr_try(8'h0F, 4'h7, 16'h0200);
   ovr_try(8'h07, 4'h0, 16'h0000);
   $display("test overrange done");
   results();
end
endmodule
`default_nettype wire
